// ### dasr_bank.sv
// One 256-word data RAM bank with a single access port
`timescale 1ns/10ps
module dasr_bank #(
    parameter int WORDS = 256
) (
    // Clock
    input  wire logic        clk,
    // Access
    input  wire logic        we,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata
);
    logic [15:0] mem [0:WORDS-1];

    // Write storage, no reset so warm reset keeps contents
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Asynchronous read gives single cycle access
    assign rdata = mem[addr];
endmodule

// ### dasr_core_model.sv
// Far-side core model: latches the external slot that a peripheral would answer on
`timescale 1ns/10ps
module dasr_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Observed strobe and slot
    input  wire logic        ext_strobe,
    input  wire logic [2:0]  external_register_slot,
    // Captured slot
    output logic [2:0]       slot_seen
);
    // Peripheral decodes the slot only while strobed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_seen <= 3'h0;
        end else if (ext_strobe) begin
            slot_seen <= external_register_slot;
        end
    end
endmodule

// ### dasr_pkg.sv
// Package of constants and carriers for the DSP address space and data RAM block
// Function
// - Internal program ROM decoded 0000H to 0FFFH
// - Interrupt vectors fetched from 0FFCH to 0FFFH
// - Reset start address held at 0FFCH
// - External variant addresses 64K program words
// - External variant vectors at FFFCH to FFFFH
// - 512 words data RAM in two banks
// - Lower bank 0-255, upper bank 256-511
// - Three address pointers for each bank
// - Pointers are eight bit, loadable and readable
// - Pointers update with modulo arithmetic
// - Indirect, direct and short direct addressing
// - One cycle per word, only pointer changes
// - Dual bank read loads both multiplier inputs
// - Warm reset keeps RAM and registers
// - Cold reset leaves RAM and registers undefined
// - Both resets clear the status word
// - 19 internal registers, eight external slots
// - Register access completes in one cycle
// - Virtual data pointers map to bank words 0-3
// - Pointers may address program memory as data
package dasr_pkg;
    localparam int DATA_W       = 16;
    localparam int PTR_W        = 8;
    localparam int BANK_WORDS   = 256;
    localparam int NUM_PTRS     = 3;
    localparam int PROG_AW      = 16;
    localparam int NUM_INT_REGS = 19;
    localparam int NUM_EXT_REGS = 8;
    localparam int NUM_VDP      = 4;

    // Program memory map
    localparam logic [15:0] INT_ROM_LAST   = 16'h0FFF;
    localparam logic [15:0] INT_PROG_LAST  = 16'h0FFB;
    localparam logic [15:0] INT_RESET_VEC  = 16'h0FFC;
    localparam logic [15:0] EXT_RESET_VEC  = 16'hFFFC;
    localparam logic [15:0] PTR_RESET      = 16'h0000;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;

    // Addressing modes of a data access
    typedef enum logic [1:0] {
        DASR_MODE_IDLE,
        DASR_MODE_INDIRECT,
        DASR_MODE_DIRECT,
        DASR_MODE_SHORT
    } dasr_mode_t;

    // Pointer step after an indirect access
    typedef enum logic [1:0] {
        DASR_STEP_NONE,
        DASR_STEP_INC,
        DASR_STEP_DEC,
        DASR_STEP_LOOP
    } dasr_step_t;

    // One data RAM request per bank
    typedef struct packed {
        dasr_mode_t  mode;
        logic        write;
        logic [1:0]  ptr_sel;
        dasr_step_t  step;
        logic [7:0]  addr;
        logic [7:0]  modulo;
        logic [15:0] wdata;
        logic        to_prog;
    } dasr_req_t;

    // Register access request from the sequencer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        is_ext;
        logic [4:0]  index;
        logic [15:0] wdata;
    } dasr_reg_req_t;

    // Internal register indices for the pointers and status word
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_PTR0   = 5'h05;
endpackage

// ### dasr_ptr_unit.sv
// Three modulo address pointers serving one data RAM bank
`timescale 1ns/10ps
module dasr_ptr_unit (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Register port
    input  wire logic                 load,
    input  wire logic [1:0]           load_sel,
    input  wire logic [7:0]           load_data,
    // Access port
    input  wire dasr_pkg::dasr_req_t  req,
    output logic [7:0]                ptr_out [0:2],
    output logic [7:0]                cur_addr
);
    import dasr_pkg::*;

    logic [7:0] bank_address_pointer [0:2];
    logic [7:0] next_ptr;
    logic [7:0] base;

    // Current pointer value and modulo step
    always_comb begin
        cur_addr = bank_address_pointer[req.ptr_sel];
        base     = cur_addr & ~req.modulo;
        unique case (req.step)
            DASR_STEP_INC:  next_ptr = base | ((cur_addr + 8'h01) & req.modulo);
            DASR_STEP_DEC:  next_ptr = base | ((cur_addr - 8'h01) & req.modulo);
            DASR_STEP_LOOP: next_ptr = base;
            DASR_STEP_NONE: next_ptr = cur_addr;
        endcase
    end

    // Pointer storage keeps value across warm reset
    always_ff @(posedge clk) begin
        if (load) begin
            bank_address_pointer[load_sel] <= load_data;
        end else if (req.mode == DASR_MODE_INDIRECT) begin
            bank_address_pointer[req.ptr_sel] <= next_ptr;
        end
    end

    assign ptr_out = bank_address_pointer;

    // Register load lands even when a step is requested
    a_ptr_load_wins: assert property (@(posedge clk) disable iff (!nrst)
        (load && load_sel == 2'h0) |=> bank_address_pointer[0] == $past(load_data))
        else $error("pointer load lost");
endmodule

// ### dasr_top.sv
// Address space decode and dual-bank data RAM with pointers
`timescale 1ns/10ps
module dasr_top #(
    parameter bit EXT_PROG = 1'b0
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // Program fetch from sequencer
    input  wire logic                    fetch,
    input  wire logic [15:0]             fetch_addr,
    input  wire logic                    vec_req,
    input  wire logic [1:0]              vec_num,
    output logic                         prog_rd,
    output logic [15:0]                  prog_addr,
    output logic                         prog_int_sel,
    output logic                         prog_err,
    // Data RAM requests, one per bank
    input  wire dasr_pkg::dasr_req_t     lower_req,
    input  wire dasr_pkg::dasr_req_t     upper_req,
    output logic [15:0]                  mul_x,
    output logic [15:0]                  mul_y,
    output logic                         dual_load,
    output logic                         prog_data_req,
    output logic [15:0]                  prog_data_addr,
    // Register access
    input  wire dasr_pkg::dasr_reg_req_t reg_req,
    input  wire logic                    status_set,
    input  wire logic [15:0]             status_in,
    output logic [15:0]                  reg_rdata,
    output logic                         reg_done,
    output logic [2:0]                   external_register_slot,
    output logic                         ext_strobe,
    output logic [15:0]                  processor_status_word
);
    import dasr_pkg::*;

    logic [7:0]  lower_ptrs [0:2];
    logic [7:0]  upper_ptrs [0:2];
    logic [7:0]  lower_cur;
    logic [7:0]  upper_cur;
    logic [7:0]  lower_addr;
    logic [7:0]  upper_addr;
    logic [15:0] lower_rdata;
    logic [15:0] upper_rdata;
    logic        lower_we;
    logic        upper_we;
    logic        lower_pload;
    logic        upper_pload;
    logic [1:0]  pload_sel;
    logic [15:0] next_rdata;
    logic [15:0] vec_base;

    // Pointer loads decoded from internal register index
    always_comb begin
        pload_sel   = 2'h0;
        lower_pload = 1'b0;
        upper_pload = 1'b0;
        if (reg_req.valid && reg_req.write && !reg_req.is_ext &&
            reg_req.index >= REG_PTR0 && reg_req.index < REG_PTR0 + 5'h06) begin
            pload_sel   = 2'((reg_req.index - REG_PTR0) >> 1);
            lower_pload = ~reg_req.index[0] ^ REG_PTR0[0];
            upper_pload = reg_req.index[0] ^ REG_PTR0[0];
        end
    end

    // Lower and upper pointer sets
    dasr_ptr_unit u_lower_ptr (
        .clk       (clk),
        .nrst      (nrst),
        .load      (lower_pload),
        .load_sel  (pload_sel),
        .load_data (reg_req.wdata[7:0]),
        .req       (lower_req),
        .ptr_out   (lower_ptrs),
        .cur_addr  (lower_cur)
    );
    dasr_ptr_unit u_upper_ptr (
        .clk       (clk),
        .nrst      (nrst),
        .load      (upper_pload),
        .load_sel  (pload_sel),
        .load_data (reg_req.wdata[7:0]),
        .req       (upper_req),
        .ptr_out   (upper_ptrs),
        .cur_addr  (upper_cur)
    );

    // Bank word address per addressing mode
    always_comb begin
        unique case (lower_req.mode)
            DASR_MODE_INDIRECT: lower_addr = lower_cur;
            DASR_MODE_SHORT:    lower_addr = {6'h00, lower_req.addr[1:0]};
            default:            lower_addr = lower_req.addr;
        endcase
        unique case (upper_req.mode)
            DASR_MODE_INDIRECT: upper_addr = upper_cur;
            DASR_MODE_SHORT:    upper_addr = {6'h00, upper_req.addr[1:0]};
            default:            upper_addr = upper_req.addr;
        endcase
    end

    // Writes go to RAM only when the request targets data space
    assign lower_we = lower_req.write && lower_req.mode != DASR_MODE_IDLE && !lower_req.to_prog;
    assign upper_we = upper_req.write && upper_req.mode != DASR_MODE_IDLE && !upper_req.to_prog;

    // Lower bank answers 0-255, upper bank 256-511
    dasr_bank #(.WORDS(BANK_WORDS)) u_lower_data_bank (
        .clk   (clk),
        .we    (lower_we),
        .addr  (lower_addr),
        .wdata (lower_req.wdata),
        .rdata (lower_rdata)
    );
    dasr_bank #(.WORDS(BANK_WORDS)) u_upper_data_bank (
        .clk   (clk),
        .we    (upper_we),
        .addr  (upper_addr),
        .wdata (upper_req.wdata),
        .rdata (upper_rdata)
    );

    // Multiplier inputs loaded per bank, mul_x on a lower bank read and mul_y on an upper bank read
    always_ff @(posedge clk) begin
        if (lower_req.mode != DASR_MODE_IDLE && !lower_req.write && !lower_req.to_prog) begin
            mul_x <= lower_rdata;
        end
        if (upper_req.mode != DASR_MODE_IDLE && !upper_req.write && !upper_req.to_prog) begin
            mul_y <= upper_rdata;
        end
    end

    // Dual load flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dual_load <= 1'b0;
        end else begin
            dual_load <= lower_req.mode != DASR_MODE_IDLE && upper_req.mode != DASR_MODE_IDLE &&
                         !lower_req.write && !upper_req.write &&
                         !lower_req.to_prog && !upper_req.to_prog;
        end
    end

    // Program memory read through a pointer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_data_req  <= 1'b0;
            prog_data_addr <= PTR_RESET;
        end else begin
            prog_data_req <= (lower_req.mode == DASR_MODE_INDIRECT && lower_req.to_prog) ||
                             (upper_req.mode == DASR_MODE_INDIRECT && upper_req.to_prog);
            if (lower_req.mode == DASR_MODE_INDIRECT && lower_req.to_prog) begin
                prog_data_addr <= {8'h00, lower_cur};
            end else if (upper_req.mode == DASR_MODE_INDIRECT && upper_req.to_prog) begin
                prog_data_addr <= {8'h00, upper_cur};
            end
        end
    end

    // Vector table base chosen by variant
    assign vec_base = EXT_PROG ? EXT_RESET_VEC : INT_RESET_VEC;

    // Program address decode and vector fetch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_rd      <= 1'b0;
            prog_addr    <= PTR_RESET;
            prog_int_sel <= 1'b0;
            prog_err     <= 1'b0;
        end else if (vec_req) begin
            prog_rd      <= 1'b1;
            prog_addr    <= vec_base + {14'h0000, vec_num};
            prog_int_sel <= !EXT_PROG;
            prog_err     <= 1'b0;
        end else if (fetch) begin
            prog_rd      <= 1'b1;
            prog_addr    <= fetch_addr;
            prog_int_sel <= !EXT_PROG && fetch_addr <= INT_ROM_LAST;
            prog_err     <= !EXT_PROG && fetch_addr > INT_PROG_LAST;
        end else begin
            prog_rd  <= 1'b0;
            prog_err <= 1'b0;
        end
    end

    // Status word cleared by every reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            processor_status_word <= STATUS_RESET;
        end else if (reg_req.valid && reg_req.write && !reg_req.is_ext && reg_req.index == REG_STATUS) begin
            processor_status_word <= reg_req.wdata;
        end else if (status_set) begin
            processor_status_word <= status_in;
        end
    end

    // Register read mux
    always_comb begin
        next_rdata = 16'h0000;
        if (!reg_req.is_ext) begin
            if (reg_req.index == REG_STATUS) begin
                next_rdata = processor_status_word;
            end else if (reg_req.index >= REG_PTR0 && reg_req.index < REG_PTR0 + 5'h06) begin
                next_rdata = (reg_req.index[0] ^ REG_PTR0[0]) ?
                             {8'h00, upper_ptrs[2'((reg_req.index - REG_PTR0) >> 1)]} :
                             {8'h00, lower_ptrs[2'((reg_req.index - REG_PTR0) >> 1)]};
            end
        end
    end

    // Single cycle register answer and external slot strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata              <= 16'h0000;
            reg_done               <= 1'b0;
            external_register_slot <= 3'h0;
            ext_strobe             <= 1'b0;
        end else begin
            reg_rdata  <= next_rdata;
            reg_done   <= reg_req.valid && (reg_req.is_ext || reg_req.index < 5'(NUM_INT_REGS));
            ext_strobe <= reg_req.valid && reg_req.is_ext;
            if (reg_req.valid && reg_req.is_ext) begin
                external_register_slot <= reg_req.index[2:0];
            end
        end
    end

    // Checks
    a_dual_load_both: assert property (@(posedge clk) disable iff (!nrst)
        (lower_req.mode == DASR_MODE_DIRECT && upper_req.mode == DASR_MODE_DIRECT &&
         !lower_req.write && !upper_req.write && !lower_req.to_prog && !upper_req.to_prog)
        |=> dual_load && mul_x == $past(lower_rdata) && mul_y == $past(upper_rdata))
        else $error("dual bank load failed");
    a_vec_internal: assert property (@(posedge clk) disable iff (!nrst)
        (vec_req && !EXT_PROG) |=> prog_addr >= INT_RESET_VEC && prog_addr <= INT_ROM_LAST)
        else $error("internal vector out of range");
    a_vec_external: assert property (@(posedge clk) disable iff (!nrst)
        (vec_req && EXT_PROG) |=> prog_addr >= EXT_RESET_VEC)
        else $error("external vector out of range");
    a_fetch_decode: assert property (@(posedge clk) disable iff (!nrst)
        (fetch && !vec_req && !EXT_PROG) |=> prog_int_sel == ($past(fetch_addr) <= INT_ROM_LAST))
        else $error("internal rom decode wrong");
    a_reg_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
        (reg_req.valid && reg_req.is_ext) |=> reg_done && ext_strobe)
        else $error("register access not single cycle");
    a_status_reset: assert property (@(posedge clk)
        $rose(nrst) |-> processor_status_word == STATUS_RESET)
        else $error("status not cleared by reset");
    a_ptr_wrap_bank: assert property (@(posedge clk) disable iff (!nrst)
        (lower_req.mode == DASR_MODE_INDIRECT && lower_req.step == DASR_STEP_INC &&
         lower_req.modulo == 8'hFF && lower_req.ptr_sel == 2'h0 && !lower_pload && lower_cur == 8'hFF)
        |=> lower_ptrs[0] == 8'h00)
        else $error("pointer did not wrap in bank");
    a_prog_data_read: assert property (@(posedge clk) disable iff (!nrst)
        (lower_req.mode == DASR_MODE_INDIRECT && lower_req.to_prog)
        |=> prog_data_req && prog_data_addr == {8'h00, $past(lower_cur)})
        else $error("pointer program read failed");

    // Request steps of register and data word accesses
    sequence s_status_write;
        reg_req.valid && reg_req.write && !reg_req.is_ext && reg_req.index == REG_STATUS;
    endsequence

    sequence s_ptr0_read;
        reg_req.valid && !reg_req.write && !reg_req.is_ext && reg_req.index == REG_PTR0;
    endsequence

    sequence s_int_beyond;
        reg_req.valid && !reg_req.is_ext && reg_req.index >= 5'(NUM_INT_REGS);
    endsequence

    sequence s_lower_direct_write;
        lower_req.mode == DASR_MODE_DIRECT && lower_req.write && !lower_req.to_prog;
    endsequence

    sequence s_lower_idle;
        lower_req.mode == DASR_MODE_IDLE;
    endsequence

    sequence s_lower_direct_read;
        lower_req.mode == DASR_MODE_DIRECT && !lower_req.write && !lower_req.to_prog;
    endsequence

    // Register answers one cycle after the request
    a_status_write: assert property (@(posedge clk) disable iff (!nrst)
        s_status_write |=> processor_status_word == $past(reg_req.wdata))
        else $error("status write not taken");
    a_ptr_read_back: assert property (@(posedge clk) disable iff (!nrst)
        s_ptr0_read |=> reg_rdata == {8'h00, $past(lower_ptrs[0])})
        else $error("pointer read back wrong");
    a_int_no_done: assert property (@(posedge clk) disable iff (!nrst)
        s_int_beyond |=> !reg_done)
        else $error("missing register answered");

    // Word written, idle cycle, same word read back
    a_ram_write_read: assert property (@(posedge clk) disable iff (!nrst)
        s_lower_direct_write ##1 s_lower_idle ##1 s_lower_direct_read ##0
        (lower_req.addr == $past(lower_req.addr, 2))
        |=> mul_x == $past(lower_req.wdata, 3))
        else $error("data word not returned");
endmodule

// ### dasr_top_tb.sv
// Self-checking testbench of the address space and data RAM block
`timescale 1ns/10ps
module dasr_top_tb;
    import dasr_pkg::*;
    logic clk, nrst, fetch, vec_req, status_set;
    logic [15:0] fetch_addr, status_in;
    logic [1:0] vec_num;
    dasr_req_t lower_req, upper_req;
    dasr_reg_req_t reg_req;
    logic prog_rd, prog_int_sel, prog_err, dual_load, prog_data_req, reg_done, ext_strobe, x_err;
    logic [15:0] prog_addr, mul_x, mul_y, prog_data_addr, reg_rdata, psw, x_addr;
    logic [2:0] slot, slot_seen;
    int failures, total_checks;

    // Internal program memory variant
    dasr_top #(.EXT_PROG(1'b0)) dasr_top_i (.clk(clk), .nrst(nrst), .fetch(fetch), .fetch_addr(fetch_addr),
        .vec_req(vec_req), .vec_num(vec_num), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_int_sel(prog_int_sel), .prog_err(prog_err), .lower_req(lower_req), .upper_req(upper_req),
        .mul_x(mul_x), .mul_y(mul_y), .dual_load(dual_load), .prog_data_req(prog_data_req),
        .prog_data_addr(prog_data_addr), .reg_req(reg_req), .status_set(status_set), .status_in(status_in),
        .reg_rdata(reg_rdata), .reg_done(reg_done), .external_register_slot(slot), .ext_strobe(ext_strobe),
        .processor_status_word(psw));
    // External program memory variant, same stimulus
    dasr_top #(.EXT_PROG(1'b1)) dasr_top_ext_i (.clk(clk), .nrst(nrst), .fetch(fetch),
        .fetch_addr(fetch_addr), .vec_req(vec_req), .vec_num(vec_num), .prog_rd(), .prog_addr(x_addr),
        .prog_int_sel(), .prog_err(x_err), .lower_req(lower_req), .upper_req(upper_req), .mul_x(),
        .mul_y(), .dual_load(), .prog_data_req(), .prog_data_addr(), .reg_req(reg_req),
        .status_set(status_set), .status_in(status_in), .reg_rdata(), .reg_done(),
        .external_register_slot(), .ext_strobe(), .processor_status_word());
    // Core side partner
    dasr_core_model dasr_core_model_i (.clk(clk), .nrst(nrst), .ext_strobe(ext_strobe),
        .external_register_slot(slot), .slot_seen(slot_seen));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One clock edge, inputs then move just after it
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    function automatic dasr_req_t rq(dasr_mode_t m, logic w, logic [1:0] s, dasr_step_t st,
                                     logic [7:0] a, logic [7:0] md, logic [15:0] d, logic tp);
        return '{mode: m, write: w, ptr_sel: s, step: st, addr: a, modulo: md, wdata: d, to_prog: tp};
    endfunction

    task automatic acc(input dasr_req_t lo, input dasr_req_t up);
        step();
        lower_req = lo;
        upper_req = up;
        step();
        lower_req = '0;
        upper_req = '0;
    endtask

    task automatic reg_acc(input logic wr, input logic ext, input logic [4:0] idx, input logic [15:0] wd);
        step();
        reg_req = '{valid: 1'b1, write: wr, is_ext: ext, index: idx, wdata: wd};
        step();
        reg_req = '0;
    endtask

    task automatic t_reset;
        check("status", 16'h0000, psw);
        check("reg_done", 16'h0000, {15'h0000, reg_done});
        $display("test reset done");
    endtask

    task automatic t_prog;
        for (int n = 0; n < 4; n++) begin
            vec_req = 1'b1;
            vec_num = n[1:0];
            fetch = 1'b1;
            fetch_addr = 16'h0100;
            step();
            check("vector int", 16'h0FFC + 16'(n), prog_addr);
            check("vector ext", 16'hFFFC + 16'(n), x_addr);
            check("int select", 16'h0001, {15'h0000, prog_int_sel});
        end
        vec_req = 1'b0;
        fetch_addr = 16'h0FFB;
        step();
        check("last code", 16'h0000, {15'h0000, prog_err});
        check("fetch addr", 16'h0FFB, prog_addr);
        check("read issued", 16'h0001, {15'h0000, prog_rd});
        fetch_addr = 16'h0FFC;
        step();
        check("vector area", 16'h0001, {15'h0000, prog_err});
        fetch_addr = 16'hF000;
        step();
        fetch = 1'b0;
        check("ext fetch", 16'hF000, x_addr);
        check("ext no err", 16'h0000, {15'h0000, x_err});
        check("rom deselect", 16'h0000, {15'h0000, prog_int_sel});
        check("high fetch err", 16'h0001, {15'h0000, prog_err});
        step();
        check("read idle", 16'h0000, {15'h0000, prog_rd});
        $display("test prog done");
    endtask

    task automatic t_ram;
        acc(rq(DASR_MODE_DIRECT, 1'b1, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'hAAAA, 1'b0),
            rq(DASR_MODE_DIRECT, 1'b1, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'h5555, 1'b0));
        acc(rq(DASR_MODE_DIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'h0000, 1'b0),
            rq(DASR_MODE_DIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'h0000, 1'b0));
        check("lower bank", 16'hAAAA, mul_x);
        check("upper bank", 16'h5555, mul_y);
        check("dual load", 16'h0001, {15'h0000, dual_load});
        acc(rq(DASR_MODE_SHORT, 1'b1, 2'h0, DASR_STEP_NONE, 8'h06, 8'hFF, 16'h1234, 1'b0), '0);
        check("single load", 16'h0000, {15'h0000, dual_load});
        acc(rq(DASR_MODE_DIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h02, 8'hFF, 16'h0000, 1'b0), '0);
        check("short word", 16'h1234, mul_x);
        check("upper kept", 16'h5555, mul_y);
        $display("test ram done");
    endtask

    task automatic t_ptr;
        acc(rq(DASR_MODE_DIRECT, 1'b1, 2'h0, DASR_STEP_NONE, 8'h00, 8'hFF, 16'hC0DE, 1'b0), '0);
        reg_acc(1'b1, 1'b0, 5'd5, 16'h00FF);
        reg_acc(1'b0, 1'b0, 5'd5, 16'h0000);
        check("ptr read", 16'h00FF, reg_rdata);
        check("reg one cycle", 16'h0001, {15'h0000, reg_done});
        acc(rq(DASR_MODE_INDIRECT, 1'b1, 2'h0, DASR_STEP_INC, 8'h00, 8'hFF, 16'hBEEF, 1'b0), '0);
        reg_acc(1'b0, 1'b0, 5'd5, 16'h0000);
        check("ptr wrap", 16'h0000, reg_rdata);
        acc(rq(DASR_MODE_INDIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h00, 8'hFF, 16'h0000, 1'b0), '0);
        check("wrap same bank", 16'hC0DE, mul_x);
        reg_acc(1'b1, 1'b0, 5'd7, 16'h002F);
        acc(rq(DASR_MODE_INDIRECT, 1'b0, 2'h1, DASR_STEP_INC, 8'h00, 8'h0F, 16'h0000, 1'b0), '0);
        reg_acc(1'b0, 1'b0, 5'd7, 16'h0000);
        check("modulo step", 16'h0020, reg_rdata);
        reg_acc(1'b1, 1'b0, 5'd10, 16'h0080);
        acc('0, rq(DASR_MODE_INDIRECT, 1'b0, 2'h2, DASR_STEP_DEC, 8'h00, 8'hFF, 16'h0000, 1'b0));
        reg_acc(1'b0, 1'b0, 5'd10, 16'h0000);
        check("upper ptr2", 16'h007F, reg_rdata);
        acc('0, rq(DASR_MODE_INDIRECT, 1'b0, 2'h2, DASR_STEP_LOOP, 8'h00, 8'h0F, 16'h0000, 1'b0));
        reg_acc(1'b0, 1'b0, 5'd10, 16'h0000);
        check("loop back", 16'h0070, reg_rdata);
        acc(rq(DASR_MODE_INDIRECT, 1'b0, 2'h1, DASR_STEP_NONE, 8'h00, 8'hFF, 16'h0000, 1'b1), '0);
        check("prog data req", 16'h0001, {15'h0000, prog_data_req});
        check("prog data addr", 16'h0020, prog_data_addr);
        $display("test ptr done");
    endtask

    task automatic t_reg;
        reg_acc(1'b1, 1'b0, 5'd4, 16'hA5A5);
        check("status write", 16'hA5A5, psw);
        status_set = 1'b1;
        status_in = 16'h1234;
        step();
        status_set = 1'b0;
        check("status core", 16'h1234, psw);
        reg_acc(1'b0, 1'b0, 5'd18, 16'h0000);
        check("last internal", 16'h0001, {15'h0000, reg_done});
        reg_acc(1'b0, 1'b0, 5'd19, 16'h0000);
        check("beyond internal", 16'h0000, {15'h0000, reg_done});
        reg_acc(1'b1, 1'b1, 5'd3, 16'h0000);
        check("ext strobe", 16'h0001, {15'h0000, ext_strobe});
        step();
        check("slot seen", 16'h0003, {13'h0000, slot_seen});
        $display("test reg done");
    endtask

    task automatic t_warm;
        nrst = 1'b0;
        repeat (3) step();
        check("status reset", 16'h0000, psw);
        nrst = 1'b1;
        acc(rq(DASR_MODE_DIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'h0000, 1'b0),
            rq(DASR_MODE_DIRECT, 1'b0, 2'h0, DASR_STEP_NONE, 8'h10, 8'hFF, 16'h0000, 1'b0));
        check("warm lower", 16'hAAAA, mul_x);
        check("warm upper", 16'h5555, mul_y);
        reg_acc(1'b0, 1'b0, 5'd7, 16'h0000);
        check("warm ptr", 16'h0020, reg_rdata);
        $display("test warm done");
    endtask

    // Watchdog cuts a hang short
    initial begin
        #400000;
        failures++;
        stop_test();
    end

    // Main sequence
    initial begin
        failures = 0;
        total_checks = 0;
        {nrst, fetch, vec_req, status_set, vec_num, fetch_addr, status_in} = '0;
        lower_req = '0;
        upper_req = '0;
        reg_req = '0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_prog();
        t_ram();
        t_ptr();
        t_reg();
        t_warm();
        stop_test();
    end
endmodule
